// [hw/stripe_track_checker.sv]
`timescale 1ns/1ps
// Behaviour
// - take one data bit on each strobe fall and append it to the store until all 1024 bits of it are filled
// - no checking during the swipe; start once card sense returns high
// - first character must be the start sentinel of the selected track
// - every character needs odd parity; an even count sets a sticky flag
// - check total folds in data bits only, parity masked off
// - look for the end sentinel; running out of data without one is an error
// - character after end sentinel is the check character; total must reach zero
// - optional limit on character count per track: 79, 40, 107
// - verdict is error if total nonzero or parity, start sentinel or length flag set, else good
// - insertion mode checks at backstop, sends clean data after withdrawal
// - failed insertion data is dropped and the withdrawal read is used
// - scan forward, on error rescan reverse; both failing reports an error
// - bits are stored contiguously so characters can straddle any boundary
// - forward framing starts at the first one bit after the clocking zeros
// - sentinel match at the boundary is rejected if next character is end sentinel
// - walk from the start sentinel end, either order, then send forward
// - check character makes each data column even and has odd parity
module stripe_track_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic dataLineN,
    input wire logic strobeN,
    input wire logic cardSenseN,
    input wire logic [1:0] trackSel,
    input wire logic lengthCheckEn,
    input wire logic insertionMode,
    input wire logic bothDirEn,
    input wire logic hostReady,
    output logic charValid,
    output logic [6:0] charData,
    output logic readGood,
    output logic readError,
    output logic busy,
    output logic reverseUsed
);

    // synchronised pin views
    logic dataLevel;
    logic strobeFall;
    logic senseFall;
    logic senseRise;

    // sequencer and scan state
    stc_pkg::stc_state_t state;
    logic [stc_pkg::BUF_BITS-1:0] bitMem;
    logic [stc_pkg::PTR_W-1:0] wrPtr;
    logic [stc_pkg::PTR_W-1:0] rdIdx;
    logic [stc_pkg::PTR_W-1:0] bitsLeft;
    logic [stc_pkg::PTR_W-1:0] startIdx;
    logic [stc_pkg::PTR_W-1:0] startLeft;
    logic [6:0] shiftCh;
    logic [6:0] lrc;
    logic [2:0] bitCnt;
    logic [7:0] charCnt;
    logic dirRev;
    logic sendPhase;
    logic parErr;
    logic ssErr;
    logic lenErr;
    logic esSeen;
    logic boundaryPending;
    logic withdrawPass;

    // per-track constants and combinational helpers
    logic [2:0] charWidth;
    logic [6:0] startPat;
    logic [6:0] dataMask;
    logic [7:0] maxChars;
    logic curBit;
    logic [6:0] next_ch;
    logic [stc_pkg::PTR_W-1:0] next_idx;
    logic [7:0] next_cnt;

    // two flops on every reader pin before any logic looks at it
    stc_pin_sync #(.INIT(1'b1)) u_data_sync (
        .clk(clk),
        .rstn(rstn),
        .pinIn(dataLineN),
        .level(dataLevel),
        .fall(),
        .rise()
    );

    stc_pin_sync #(.INIT(1'b1)) u_strobe_sync (
        .clk(clk),
        .rstn(rstn),
        .pinIn(strobeN),
        .level(),
        .fall(strobeFall),
        .rise()
    );

    stc_pin_sync #(.INIT(1'b1)) u_sense_sync (
        .clk(clk),
        .rstn(rstn),
        .pinIn(cardSenseN),
        .level(),
        .fall(senseFall),
        .rise(senseRise)
    );

    // track dependent width, start pattern, mask and length limit
    always_comb begin
        if (trackSel == stc_pkg::TRACK_ONE) begin
            charWidth = stc_pkg::WIDTH_LONG;
            startPat = stc_pkg::START_LONG;
            dataMask = stc_pkg::MASK_LONG;
            maxChars = stc_pkg::MAX_ONE;
        end else if (trackSel == stc_pkg::TRACK_TWO) begin
            charWidth = stc_pkg::WIDTH_SHORT;
            startPat = stc_pkg::START_SHORT;
            dataMask = stc_pkg::MASK_SHORT;
            maxChars = stc_pkg::MAX_TWO;
        end else begin
            charWidth = stc_pkg::WIDTH_SHORT;
            startPat = stc_pkg::START_SHORT;
            dataMask = stc_pkg::MASK_SHORT;
            maxChars = stc_pkg::MAX_THREE;
        end
    end

    // bit under the read index; the index walks up or down the store
    assign curBit = bitMem[rdIdx[stc_pkg::IDX_W-1:0]];
    assign next_idx = dirRev ? (rdIdx - stc_pkg::PTR_ONE) : (rdIdx + stc_pkg::PTR_ONE);
    assign next_cnt = charCnt + stc_pkg::CNT_ONE;

    // character assembly, first stripe bit lands in bit 0
    always_comb begin
        next_ch = (bitCnt == stc_pkg::BIT_RESET) ? stc_pkg::CHAR_RESET : shiftCh;
        next_ch[bitCnt] = curBit;
    end

    // bit capture; data low on the line is a one bit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= stc_pkg::PTR_RESET;
        end else if (state == stc_pkg::ST_IDLE && senseFall) begin
            wrPtr <= stc_pkg::PTR_RESET;
        end else if (state == stc_pkg::ST_CAPT && strobeFall && wrPtr != stc_pkg::PTR_FULL) begin
            wrPtr <= wrPtr + stc_pkg::PTR_ONE;
        end
    end

    // bit store, plain flops with no reset
    always_ff @(posedge clk) begin
        if (state == stc_pkg::ST_CAPT && strobeFall && wrPtr != stc_pkg::PTR_FULL) begin
            bitMem[wrPtr[stc_pkg::IDX_W-1:0]] <= ~dataLevel;
        end
    end

    // sequencer: capture, scan, verdict, retry policy and sending
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= stc_pkg::ST_IDLE;
            rdIdx <= stc_pkg::PTR_RESET;
            bitsLeft <= stc_pkg::PTR_RESET;
            startIdx <= stc_pkg::PTR_RESET;
            startLeft <= stc_pkg::PTR_RESET;
            shiftCh <= stc_pkg::CHAR_RESET;
            lrc <= stc_pkg::CHAR_RESET;
            bitCnt <= stc_pkg::BIT_RESET;
            charCnt <= stc_pkg::CNT_RESET;
            dirRev <= 1'b0;
            sendPhase <= 1'b0;
            parErr <= 1'b0;
            ssErr <= 1'b0;
            lenErr <= 1'b0;
            esSeen <= 1'b0;
            boundaryPending <= 1'b0;
            withdrawPass <= 1'b0;
            charValid <= 1'b0;
            charData <= stc_pkg::CHAR_RESET;
            readGood <= 1'b0;
            readError <= 1'b0;
            reverseUsed <= 1'b0;
        end else begin
            charValid <= 1'b0;
            readGood <= 1'b0;
            readError <= 1'b0;
            case (state)
                // wait for the card to reach the head
                stc_pkg::ST_IDLE: begin
                    if (senseFall) begin
                        state <= stc_pkg::ST_CAPT;
                    end
                end
                // store bits only; checking waits for card sense high
                stc_pkg::ST_CAPT: begin
                    if (senseRise) begin
                        state <= stc_pkg::ST_SCAN_START;
                        dirRev <= 1'b0;
                    end
                end
                // reset the checker and point at the chosen end
                stc_pkg::ST_SCAN_START: begin
                    rdIdx <= dirRev ? (wrPtr - stc_pkg::PTR_ONE) : stc_pkg::PTR_RESET;
                    bitsLeft <= wrPtr;
                    lrc <= stc_pkg::CHAR_RESET;
                    parErr <= 1'b0;
                    ssErr <= 1'b0;
                    lenErr <= 1'b0;
                    esSeen <= 1'b0;
                    boundaryPending <= 1'b0;
                    charCnt <= stc_pkg::CNT_RESET;
                    bitCnt <= stc_pkg::BIT_RESET;
                    sendPhase <= 1'b0;
                    state <= stc_pkg::ST_FIND;
                end
                // skip clocking zeros; the first one bit opens framing
                stc_pkg::ST_FIND: begin
                    if (bitsLeft == stc_pkg::PTR_RESET) begin
                        state <= stc_pkg::ST_FAIL;
                    end else if (curBit) begin
                        startIdx <= rdIdx;
                        startLeft <= bitsLeft;
                        state <= stc_pkg::ST_CHAR;
                    end else begin
                        rdIdx <= next_idx;
                        bitsLeft <= bitsLeft - stc_pkg::PTR_ONE;
                    end
                end
                // gather one character bit per cycle
                stc_pkg::ST_CHAR: begin
                    if (bitsLeft == stc_pkg::PTR_RESET) begin
                        state <= stc_pkg::ST_FAIL;
                    end else begin
                        shiftCh <= next_ch;
                        rdIdx <= next_idx;
                        bitsLeft <= bitsLeft - stc_pkg::PTR_ONE;
                        if (bitCnt == charWidth - 3'h1) begin
                            bitCnt <= stc_pkg::BIT_RESET;
                            state <= stc_pkg::ST_EVAL;
                        end else begin
                            bitCnt <= bitCnt + 3'h1;
                        end
                    end
                end
                // check or send the completed character
                stc_pkg::ST_EVAL: begin
                    if (sendPhase) begin
                        if (hostReady) begin
                            charValid <= 1'b1;
                            charData <= shiftCh;
                            if (esSeen) begin
                                readGood <= 1'b1;
                                withdrawPass <= 1'b0;
                                state <= stc_pkg::ST_IDLE;
                            end else begin
                                esSeen <= (shiftCh == stc_pkg::END_MARK);
                                state <= stc_pkg::ST_CHAR;
                            end
                        end
                    end else begin
                        if (~^shiftCh) begin
                            parErr <= 1'b1;
                        end
                        lrc <= lrc ^ (shiftCh & dataMask);
                        charCnt <= next_cnt;
                        if (lengthCheckEn && next_cnt > maxChars) begin
                            lenErr <= 1'b1;
                        end
                        if (charCnt == stc_pkg::CNT_RESET) begin
                            ssErr <= (shiftCh != startPat);
                            boundaryPending <= (shiftCh == startPat);
                        end
                        if (charCnt == stc_pkg::CNT_ONE && boundaryPending && shiftCh == stc_pkg::END_MARK) begin
                            ssErr <= 1'b1;
                        end
                        if (esSeen) begin
                            state <= stc_pkg::ST_VERDICT;
                        end else begin
                            esSeen <= (shiftCh == stc_pkg::END_MARK);
                            state <= stc_pkg::ST_CHAR;
                        end
                    end
                end
                // total must be zero and no error flag raised
                stc_pkg::ST_VERDICT: begin
                    if (lrc == stc_pkg::CHAR_RESET && !parErr && !ssErr && !lenErr) begin
                        reverseUsed <= dirRev;
                        if (insertionMode && !withdrawPass) begin
                            state <= stc_pkg::ST_HOLD;
                        end else begin
                            state <= stc_pkg::ST_SEND_LOAD;
                        end
                    end else begin
                        state <= stc_pkg::ST_FAIL;
                    end
                end
                // retry in reverse, then on withdrawal, then report
                stc_pkg::ST_FAIL: begin
                    if (bothDirEn && !dirRev) begin
                        dirRev <= 1'b1;
                        state <= stc_pkg::ST_SCAN_START;
                    end else if (insertionMode && !withdrawPass) begin
                        withdrawPass <= 1'b1;
                        state <= stc_pkg::ST_IDLE;
                    end else begin
                        readError <= 1'b1;
                        withdrawPass <= 1'b0;
                        state <= stc_pkg::ST_IDLE;
                    end
                end
                // good insertion data waits for the withdrawal stroke
                stc_pkg::ST_HOLD: begin
                    if (senseFall) begin
                        state <= stc_pkg::ST_HOLD_OUT;
                    end
                end
                // card clear of the head again: release the data
                stc_pkg::ST_HOLD_OUT: begin
                    if (senseRise) begin
                        state <= stc_pkg::ST_SEND_LOAD;
                    end
                end
                // replay from the start sentinel in the passing direction
                stc_pkg::ST_SEND_LOAD: begin
                    rdIdx <= startIdx;
                    bitsLeft <= startLeft;
                    bitCnt <= stc_pkg::BIT_RESET;
                    esSeen <= 1'b0;
                    sendPhase <= 1'b1;
                    state <= stc_pkg::ST_CHAR;
                end
                default: begin
                    state <= stc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // busy while anything but idle, so also low while idle waits for a withdrawal read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != stc_pkg::ST_IDLE);
        end
    end

endmodule : stripe_track_checker

// [hw/stc_pkg.sv]
package stc_pkg;

    // bit store sizing
    localparam int BUF_BITS = 1024;
    localparam int IDX_W = 10;
    localparam int PTR_W = 11;
    localparam logic [PTR_W-1:0] PTR_RESET = 11'h000;
    localparam logic [PTR_W-1:0] PTR_ONE = 11'h001;
    localparam logic [PTR_W-1:0] PTR_FULL = 11'h400;

    // track selection codes
    localparam logic [1:0] TRACK_ONE = 2'h1;
    localparam logic [1:0] TRACK_TWO = 2'h2;
    localparam logic [1:0] TRACK_THREE = 2'h3;

    // character widths in bits, parity included
    localparam logic [2:0] WIDTH_SHORT = 3'h5;
    localparam logic [2:0] WIDTH_LONG = 3'h7;
    localparam logic [2:0] BIT_RESET = 3'h0;

    // sentinel patterns and data masks, lsb is the first bit on the stripe
    localparam logic [6:0] START_SHORT = 7'h0b;
    localparam logic [6:0] START_LONG = 7'h45;
    localparam logic [6:0] END_MARK = 7'h1f;
    localparam logic [6:0] MASK_SHORT = 7'h0f;
    localparam logic [6:0] MASK_LONG = 7'h3f;
    localparam logic [6:0] CHAR_RESET = 7'h00;

    // longest legal character count per track
    localparam logic [7:0] MAX_ONE = 8'h4f;
    localparam logic [7:0] MAX_TWO = 8'h28;
    localparam logic [7:0] MAX_THREE = 8'h6b;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CAPT,
        ST_SCAN_START,
        ST_FIND,
        ST_CHAR,
        ST_EVAL,
        ST_VERDICT,
        ST_FAIL,
        ST_HOLD,
        ST_HOLD_OUT,
        ST_SEND_LOAD
    } stc_state_t;

endpackage : stc_pkg

// [hw/stc_pin_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser for one reader pin, with registered edge pulses
module stc_pin_sync #(
    parameter logic INIT = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pinIn,
    output logic level,
    output logic fall,
    output logic rise
);

    logic meta;
    logic stable;

    // meta feeds only stable; edges compare stable with the held level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= INIT;
            stable <= INIT;
            level <= INIT;
            fall <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= pinIn;
            stable <= meta;
            level <= stable;
            fall <= level & ~stable;
            rise <= ~level & stable;
        end
    end

endmodule : stc_pin_sync

// [verification/stc_reader_model.sv]
`timescale 1ns/1ps
// reader side of the pins: plays a card image at a 200 ns strobe period
module stc_reader_model #(
    parameter int HALF_NS = 100,
    parameter int SENSE_HOLD_NS = 2000 // shortened card sense timeout
) (
    output logic dataLineN,
    output logic strobeN,
    output logic cardSenseN
);
    // quiet pins sit high while no card moves
    initial begin
        dataLineN = 1'b1;
        strobeN = 1'b1;
        cardSenseN = 1'b1;
    end

    // one pass of the card past the head, strobe stands still outside it
    task automatic swipe(input bit bits[$]);
        cardSenseN = 1'b0;
        #(4 * HALF_NS);
        foreach (bits[i]) begin
            dataLineN = ~bits[i];
            #(HALF_NS);
            strobeN = 1'b0;
            #(HALF_NS);
            strobeN = 1'b1;
        end
        dataLineN = 1'b1;
        #(SENSE_HOLD_NS);
        cardSenseN = 1'b1;
    endtask : swipe
endmodule : stc_reader_model

// [verification/stc_asserts.sv]
`timescale 1ns/1ps
// timing and content checks on the host side results
module stc_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cardSenseN,
    input wire logic [1:0] trackSel,
    input wire logic charValid,
    input wire logic [6:0] charData,
    input wire logic readGood,
    input wire logic readError,
    input wire logic reverseUsed
);
    logic burstStart;
    logic [6:0] sum;
    logic [6:0] prevChar;
    logic [6:0] mask;

    // data bit mask of the selected track
    assign mask = (trackSel == stc_pkg::TRACK_ONE) ? stc_pkg::MASK_LONG : stc_pkg::MASK_SHORT;

    // high until the first character of a burst is sent
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burstStart <= 1'b1;
        end else if (readGood || readError) begin
            burstStart <= 1'b1;
        end else if (charValid) begin
            burstStart <= 1'b0;
        end
    end

    // running fold of sent data bits and the previous character
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sum <= 7'h00;
            prevChar <= 7'h00;
        end else if (charValid) begin
            sum <= (burstStart ? 7'h00 : sum) ^ (charData & mask);
            prevChar <= charData;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_verdict_excl;
        !(readGood && readError);
    endproperty
    a_verdict_excl: assert property (p_verdict_excl) else $error("good and error together");
    property p_good_on_check;
        readGood |-> charValid;
    endproperty
    a_good_on_check: assert property (p_good_on_check) else $error("good without check char");
    property p_quiet_swipe;
        !cardSenseN [*4] |-> !(charValid || readGood || readError);
    endproperty
    a_quiet_swipe: assert property (p_quiet_swipe) else $error("output while card on head");
    property p_spacing;
        charValid |=> !charValid [*5];
    endproperty
    a_spacing: assert property (p_spacing) else $error("characters too close");
    property p_first_start;
        charValid && burstStart |-> charData == ((trackSel == stc_pkg::TRACK_ONE) ?
            stc_pkg::START_LONG : stc_pkg::START_SHORT);
    endproperty
    a_first_start: assert property (p_first_start) else $error("burst not led by start char");
    property p_odd_parity;
        charValid |-> ^charData;
    endproperty
    a_odd_parity: assert property (p_odd_parity) else $error("even parity char sent");
    property p_check_zero;
        readGood |-> ((sum ^ charData) & mask) == 7'h00;
    endproperty
    a_check_zero: assert property (p_check_zero) else $error("check total not zero");
    property p_end_before_check;
        readGood |-> prevChar == stc_pkg::END_MARK;
    endproperty
    a_end_before_check: assert property (p_end_before_check) else $error("no end char");
    property p_no_data_on_error;
        readError |-> burstStart && !charValid;
    endproperty
    a_no_data_on_error: assert property (p_no_data_on_error) else $error("data sent on error");

    c_good_reverse: cover property (readGood && reverseUsed);
    c_error: cover property (readError);
    c_long_char: cover property (charValid && trackSel == stc_pkg::TRACK_ONE);
endmodule : stc_asserts

bind stripe_track_checker stc_asserts i_chk (.clk(clk), .rstn(rstn), .cardSenseN(cardSenseN),
    .trackSel(trackSel), .charValid(charValid), .charData(charData), .readGood(readGood),
    .readError(readError), .reverseUsed(reverseUsed));

// [verification/stripe_track_checker_bench.sv]
`timescale 1ns/1ps
// self-checking bench: card images through the reader model, results from the host side
module stripe_track_checker_bench;
    logic clk;
    logic rstn;
    logic dataLineN;
    logic strobeN;
    logic cardSenseN;
    logic [1:0] trackSel;
    logic lengthCheckEn;
    logic insertionMode;
    logic bothDirEn;
    logic hostReady;
    logic charValid;
    logic [6:0] charData;
    logic readGood;
    logic readError;
    logic busy;
    logic reverseUsed;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int goods = 0;
    int errs = 0;
    int g0;
    int e0;
    logic [6:0] gotQ[$];
    logic [6:0] expQ[$];
    logic [6:0] keepQ[$];
    bit bitsQ[$];

    stripe_track_checker i_dut (.clk(clk), .rstn(rstn), .dataLineN(dataLineN), .strobeN(strobeN),
        .cardSenseN(cardSenseN), .trackSel(trackSel), .lengthCheckEn(lengthCheckEn),
        .insertionMode(insertionMode), .bothDirEn(bothDirEn), .hostReady(hostReady),
        .charValid(charValid), .charData(charData), .readGood(readGood), .readError(readError),
        .busy(busy), .reverseUsed(reverseUsed));
    stc_reader_model i_rdr (.dataLineN(dataLineN), .strobeN(strobeN), .cardSenseN(cardSenseN));

    // system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // collect host side results and cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (charValid === 1'b1) gotQ.push_back(charData);
        if (readGood === 1'b1) goods <= goods + 1;
        if (readError === 1'b1) errs <= errs + 1;
        if (cycles == 60000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    task automatic set_mode(input logic [1:0] tr, input logic len, input logic ins, input logic both);
        @(posedge clk);
        trackSel <= tr;
        lengthCheckEn <= len;
        insertionMode <= ins;
        bothDirEn <= both;
    endtask : set_mode

    // card image: zeros, start, n data chars, end, check char, zeros
    // mode 1 spoils the check char, 2 drops the end char, 3 spoils a parity bit
    task automatic frame(input int w, input int n, input int mode);
        logic [6:0] m;
        logic [6:0] c;
        logic [6:0] lrc;
        m = (w == 5) ? stc_pkg::MASK_SHORT : stc_pkg::MASK_LONG;
        lrc = 7'h00;
        bitsQ = {};
        expQ = {};
        repeat (8) bitsQ.push_back(1'b0);
        for (int k = 0; k < n + 3; k++) begin
            c = 7'(k % 10);
            if (k == 0) c = (w == 5) ? stc_pkg::START_SHORT : stc_pkg::START_LONG;
            if (k == n + 1 && mode != 2) c = stc_pkg::END_MARK;
            if (k == n + 2) c = lrc ^ ((mode == 1) ? 7'h01 : 7'h00);
            c = (c & m) | (7'(~^(c & m)) << (w - 1));
            if (k == 1 && mode == 3) c = c ^ (7'h01 << (w - 1));
            lrc = lrc ^ (c & m);
            expQ.push_back(c);
            for (int i = 0; i < w; i++) bitsQ.push_back(c[i]);
        end
        repeat (8) bitsQ.push_back(1'b0);
    endtask : frame

    task automatic arm();
        gotQ = {};
        g0 = goods;
        e0 = errs;
    endtask : arm

    // wait for one verdict and judge it with what was sent
    task automatic verdict(input bit good, input logic rev);
        int t;
        t = 0;
        while (goods == g0 && errs == e0 && t < 5000) begin
            @(negedge clk);
            t++;
        end
        compare(8'(goods - g0), {7'h00, good});
        compare(8'(errs - e0), {7'h00, !good});
        compare(8'(gotQ.size()), good ? 8'(expQ.size()) : 8'h00);
        if (good) begin
            compare({7'h00, reverseUsed}, {7'h00, rev});
            foreach (expQ[i]) compare({1'b0, gotQ[i]}, {1'b0, expQ[i]});
        end
    endtask : verdict

    task automatic run(input bit good, input logic rev);
        arm();
        i_rdr.swipe(bitsQ);
        verdict(good, rev);
    endtask : run

    // good cards on track codes one to three
    task automatic t_tracks();
        for (int tr = 1; tr < 4; tr++) begin
            set_mode(2'(tr), 1'b0, 1'b0, 1'b0);
            frame((tr == 1) ? 7 : 5, 6, 0);
            run(1'b1, 1'b0);
        end
    endtask : t_tracks

    // bad check char, missing end char, parity error; both directions fail
    task automatic t_faults();
        set_mode(2'h2, 1'b0, 1'b0, 1'b1);
        for (int md = 1; md < 4; md++) begin
            frame(5, 6, md);
            run(1'b0, 1'b0);
        end
    endtask : t_faults

    // reversed swipe fails forward, passes only with the reverse rescan
    task automatic t_reverse();
        for (int b = 0; b < 2; b++) begin
            set_mode(2'h2, 1'b0, 1'b0, 1'(b));
            frame(5, 6, 0);
            bitsQ.reverse();
            run(1'(b), 1'b1);
        end
    endtask : t_reverse

    // 40 characters pass the track two limit, 41 do not
    task automatic t_length();
        set_mode(2'h2, 1'b1, 1'b0, 1'b0);
        for (int n = 37; n < 39; n++) begin
            frame(5, n, 0);
            run(n == 37, 1'b0);
        end
    endtask : t_length

    // host holds off: nothing sent until it is ready, order kept
    task automatic t_stall();
        set_mode(2'h3, 1'b0, 1'b0, 1'b0);
        hostReady <= 1'b0;
        frame(5, 4, 0);
        arm();
        i_rdr.swipe(bitsQ);
        repeat (600) @(negedge clk);
        compare(8'(gotQ.size()), 8'h00);
        compare({7'h00, busy}, 8'h01);
        @(posedge clk);
        hostReady <= 1'b1;
        verdict(1'b1, 1'b0);
    endtask : t_stall

    // insertion: good kept over a spoilt withdrawal, bad retried, bad twice reported
    task automatic t_insertion();
        set_mode(2'h2, 1'b0, 1'b1, 1'b0);
        for (int c = 0; c < 3; c++) begin
            frame(5, 6, (c == 0) ? 0 : 3);
            keepQ = expQ;
            arm();
            i_rdr.swipe(bitsQ);
            repeat (400) @(negedge clk);
            compare(8'(gotQ.size() + goods + errs - g0 - e0), 8'h00);
            frame(5, 5, (c == 0) ? 1 : ((c == 1) ? 0 : 3));
            i_rdr.swipe(bitsQ);
            if (c == 0) expQ = keepQ;
            verdict(c != 2, 1'b0);
        end
    endtask : t_insertion

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // main sequence
    initial begin
        rstn = 1'b0;
        trackSel = 2'h2;
        lengthCheckEn = 1'b0;
        insertionMode = 1'b0;
        bothDirEn = 1'b0;
        hostReady = 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_tracks();
        t_faults();
        t_reverse();
        t_length();
        t_stall();
        t_insertion();
        end_of_test();
    end
endmodule : stripe_track_checker_bench
